/* hdl/pzr_pkg.sv */
package pzr_pkg;
    localparam int CPU_AW = 14;
    localparam int OFS_W = 5;
    localparam int WB_AW = 16;
    localparam int BYTE_W = 8;
    // Memory map, in CPU byte addresses
    localparam logic [13:0] IO_BASE = 14'h0000;
    localparam logic [13:0] IO_LAST = 14'h001f;
    localparam logic [13:0] ROM_BASE = 14'h3f00;
    localparam logic [13:0] ROM_BYTES = 14'h00ef;
    localparam logic [13:0] OPT_ADDR = 14'h3fef;
    localparam logic [13:0] MOR1_ADDR = 14'h3ff0;
    localparam logic [13:0] MOR2_ADDR = 14'h3ff1;
    localparam logic [13:0] WDOG_ALT_ADDR = 14'h3ff0;
    // Page-zero register indices; byte address on the bus is four times these
    localparam logic [4:0] OFS_PORT_A_PIN_DATA = 5'h00;
    localparam logic [4:0] OFS_PORT_D_PIN_DATA = 5'h03;
    localparam logic [4:0] OFS_PORT_A_DIRECTION = 5'h04;
    localparam logic [4:0] OFS_PORT_D_DIRECTION = 5'h07;
    localparam logic [4:0] OFS_UNUSED_SLOT_EIGHT = 5'h08;
    localparam logic [4:0] OFS_UNUSED_SLOT_NINE = 5'h09;
    localparam logic [4:0] OFS_SYNC_SERIAL_CONTROL = 5'h0a;
    localparam logic [4:0] OFS_SYNC_SERIAL_STATUS = 5'h0b;
    localparam logic [4:0] OFS_SYNC_SERIAL_BUFFER = 5'h0c;
    localparam logic [4:0] OFS_ASYNC_RATE_SELECT = 5'h0d;
    localparam logic [4:0] OFS_ASYNC_CONTROL_ONE = 5'h0e;
    localparam logic [4:0] OFS_ASYNC_CONTROL_TWO = 5'h0f;
    localparam logic [4:0] OFS_ASYNC_FLAGS = 5'h10;
    localparam logic [4:0] OFS_ASYNC_BUFFER = 5'h11;
    localparam logic [4:0] OFS_TIMER_SETUP = 5'h12;
    localparam logic [4:0] OFS_TIMER_FLAGS = 5'h13;
    localparam logic [4:0] OFS_CAPTURE_VALUE_HIGH = 5'h14;
    localparam logic [4:0] OFS_CAPTURE_VALUE_LOW = 5'h15;
    localparam logic [4:0] OFS_COMPARE_VALUE_HIGH = 5'h16;
    localparam logic [4:0] OFS_COMPARE_VALUE_LOW = 5'h17;
    localparam logic [4:0] OFS_FREE_COUNTER_HIGH = 5'h18;
    localparam logic [4:0] OFS_FREE_COUNTER_LOW = 5'h19;
    localparam logic [4:0] OFS_ALT_COUNTER_HIGH = 5'h1a;
    localparam logic [4:0] OFS_ALT_COUNTER_LOW = 5'h1b;
    localparam logic [4:0] OFS_PROGRAM_MEMORY_CONTROL = 5'h1c;
    localparam logic [4:0] OFS_WATCHDOG_SERVICE = 5'h1d;
    localparam logic [4:0] OFS_WATCHDOG_SETUP = 5'h1e;
    localparam logic [4:0] OFS_RESERVED_SLOT_TOP = 5'h1f;
    // Field layouts and reset values
    localparam logic [7:0] PORT_FULL_MASK = 8'hff;
    localparam logic [7:0] PORT_D_IMPL_MASK = 8'hbf;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int MOR2_SEC_BIT = 3;

    typedef enum logic [2:0] {
        PZR_ACC_PORT_DATA,
        PZR_ACC_PORT_DIR,
        PZR_ACC_NONE,
        PZR_ACC_RW,
        PZR_ACC_RO,
        PZR_ACC_WO
    } pzr_acc_t;

    function automatic pzr_acc_t pzr_acc_kind(input logic [4:0] ofs);
        pzr_acc_t k;
        k = PZR_ACC_RW;
        if (ofs <= OFS_PORT_D_PIN_DATA) k = PZR_ACC_PORT_DATA;
        else if (ofs <= OFS_PORT_D_DIRECTION) k = PZR_ACC_PORT_DIR;
        else if (ofs == OFS_UNUSED_SLOT_EIGHT || ofs == OFS_UNUSED_SLOT_NINE ||
                 ofs == OFS_RESERVED_SLOT_TOP) k = PZR_ACC_NONE;
        else if (ofs == OFS_WATCHDOG_SERVICE) k = PZR_ACC_WO;
        else if (ofs == OFS_ASYNC_FLAGS || ofs == OFS_TIMER_FLAGS ||
                 (ofs >= OFS_CAPTURE_VALUE_HIGH && ofs <= OFS_CAPTURE_VALUE_LOW) ||
                 (ofs >= OFS_FREE_COUNTER_HIGH && ofs <= OFS_ALT_COUNTER_LOW))
            k = PZR_ACC_RO;
        return k;
    endfunction

    function automatic logic pzr_in_range(input logic [13:0] a, input logic [13:0] lo,
                                          input logic [13:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction
endpackage

/* hdl/pzr_port.sv */
`timescale 1ns/1ns
module pzr_port
    import pzr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] pin_i,
    input wire logic data_we_i,
    input wire logic dir_we_i,
    input wire logic [7:0] wdat_i,
    input wire logic [7:0] impl_mask_i,
    input wire logic [7:0] dir_mask_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] data_rd_o,
    output logic [7:0] dir_rd_o
);
    logic [7:0] data_r;
    logic [7:0] dir_r;
    logic [7:0] pin_meta_r;
    logic [7:0] pin_sync_r;

    // No reset on the latch: contents survive reset
    always_ff @(posedge clk_i) begin
        if (ce_i && data_we_i) begin
            data_r <= wdat_i & impl_mask_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_r <= DIR_RESET;
        end else if (ce_i && dir_we_i) begin
            dir_r <= wdat_i & dir_mask_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            pin_meta_r <= pin_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Gating with direction keeps the pins defined before the first write
    assign pin_o = data_r & dir_r;
    assign pin_oe_o = dir_r;
    assign data_rd_o = ((dir_r & data_r) | (~dir_r & pin_sync_r)) & impl_mask_i;
    assign dir_rd_o = dir_r & dir_mask_i;
endmodule

/* hdl/pzr_regmap.sv */
`timescale 1ns/1ns
// Overview of operation
// - Security lock stays set until full erase
// - Lock blocks every external memory read
// - One-time-programmable parts never clear the lock
// - Bootloader ROM: 239 read-only bytes below options
// - Bootloader mode executes from the ROM
// - I/O registers live in 32-byte page-zero window
// - Option and mask option registers sit outside
// - Offsets 0-3 are port pin data
// - Offsets 4-7 direction, cleared on reset
// - Port D direction only in large configuration
// - Sync serial registers at 0x0A-0x0C
// - Async serial registers at 0x0D-0x11
// - Timer registers at 0x12-0x1B
// - 0x1C program control, 0x1D-0x1E watchdog
module pzr_regmap
    import pzr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] port_a_pin_i,
    input wire logic [7:0] port_b_pin_i,
    input wire logic [7:0] port_c_pin_i,
    input wire logic [7:0] port_d_pin_i,
    output logic [7:0] port_a_pin_o,
    output logic [7:0] port_b_pin_o,
    output logic [7:0] port_c_pin_o,
    output logic [7:0] port_d_pin_o,
    output logic [7:0] port_a_pin_oe_o,
    output logic [7:0] port_b_pin_oe_o,
    output logic [7:0] port_c_pin_oe_o,
    output logic [7:0] port_d_pin_oe_o,
    output logic per_wr_o,
    output logic per_rd_o,
    output logic [4:0] per_idx_o,
    output logic [7:0] per_wdat_o,
    input wire logic [7:0] per_rdat_i,
    output logic [7:0] rom_adr_o,
    input wire logic [7:0] rom_dat_i,
    output logic rom_exec_o,
    input wire logic boot_mode_i,
    input wire logic large_cfg_i,
    input wire logic otp_part_i,
    input wire logic sec_nv_i,
    input wire logic [15:0] mor_i,
    output logic sec_burn_o,
    input wire logic erase_done_i,
    input wire logic ext_rd_req_i,
    input wire logic [7:0] ext_mem_dat_i,
    output logic ext_rd_grant_o,
    output logic [7:0] ext_rd_dat_o,
    output logic wdog_alt_clr_o,
    output logic [7:0] option_o,
    output logic sec_lock_o
);
    logic ack_r;
    logic [31:0] dat_r;
    logic [4:0] per_idx_r;
    logic [7:0] per_wdat_r;
    logic [7:0] opt_r;
    logic lock_r;
    logic large_r;
    logic otp_r;
    logic [7:0] ext_dat_r;
    // Two-flop synchronisers for pins and straps
    logic [3:0] strap_meta_r;
    logic [3:0] strap_sync_r;

    wire logic boot_s = strap_sync_r[0];
    wire logic large_s = strap_sync_r[1];
    wire logic otp_s = strap_sync_r[2];
    wire logic sec_nv_s = strap_sync_r[3];

    // Decode
    wire logic req = cyc_i & stb_i;
    wire logic [13:0] cpu_adr = adr_i[15:2];
    wire logic [4:0] ofs = cpu_adr[4:0];
    wire logic take = req & ~ack_r;
    wire logic commit = req & ack_r & ce_i;
    wire logic wr_ok = commit & we_i & sel_i[0];
    wire logic rd_ok = commit & ~we_i;
    wire logic [7:0] wbyte = dat_i[7:0];
    wire logic [13:0] rom_last = ROM_BASE + ROM_BYTES - 14'h0001;
    wire logic hit_io = pzr_in_range(cpu_adr, IO_BASE, IO_LAST);
    wire logic hit_rom = pzr_in_range(cpu_adr, ROM_BASE, rom_last);
    wire logic hit_opt = pzr_in_range(cpu_adr, OPT_ADDR, OPT_ADDR);
    wire logic hit_mor1 = pzr_in_range(cpu_adr, MOR1_ADDR, MOR1_ADDR);
    wire logic hit_mor2 = pzr_in_range(cpu_adr, MOR2_ADDR, MOR2_ADDR);
    wire logic hit_walt = pzr_in_range(cpu_adr, WDOG_ALT_ADDR, WDOG_ALT_ADDR);
    wire pzr_acc_t kind = pzr_acc_kind(ofs);
    wire logic is_port_data = hit_io & (kind == PZR_ACC_PORT_DATA);
    wire logic is_port_dir = hit_io & (kind == PZR_ACC_PORT_DIR);
    // Serial, timer, programming and watchdog slots go out to the peripherals
    wire logic is_per = hit_io & ((kind == PZR_ACC_RW) | (kind == PZR_ACC_RO) |
                                  (kind == PZR_ACC_WO));
    wire logic per_writable = (kind == PZR_ACC_RW) | (kind == PZR_ACC_WO);
    wire logic per_readable = (kind == PZR_ACC_RW) | (kind == PZR_ACC_RO);
    wire logic [1:0] port_sel = ofs[1:0];

    // Port instances
    logic [7:0] pin_in [4];
    logic [7:0] pin_out [4];
    logic [7:0] pin_oe [4];
    logic [7:0] port_data_rd [4];
    logic [7:0] port_dir_rd [4];
    logic [7:0] impl_mask [4];
    logic [7:0] dir_mask [4];

    assign pin_in[0] = port_a_pin_i;
    assign pin_in[1] = port_b_pin_i;
    assign pin_in[2] = port_c_pin_i;
    assign pin_in[3] = port_d_pin_i;
    assign port_a_pin_o = pin_out[0];
    assign port_b_pin_o = pin_out[1];
    assign port_c_pin_o = pin_out[2];
    assign port_d_pin_o = pin_out[3];
    assign port_a_pin_oe_o = pin_oe[0];
    assign port_b_pin_oe_o = pin_oe[1];
    assign port_c_pin_oe_o = pin_oe[2];
    assign port_d_pin_oe_o = pin_oe[3];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_port
            localparam logic [1:0] IDX = 2'(gi);
            localparam logic IS_D = (gi == 3);
            wire logic data_we = wr_ok & is_port_data & (port_sel == IDX);
            wire logic dir_we = wr_ok & is_port_dir & (port_sel == IDX);

            assign impl_mask[gi] = IS_D ? PORT_D_IMPL_MASK : PORT_FULL_MASK;
            // Without the large configuration there is no port D direction latch
            assign dir_mask[gi] = IS_D ? (large_r ? PORT_D_IMPL_MASK : BYTE_ZERO)
                                       : PORT_FULL_MASK;

            pzr_port u_port (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .pin_i(pin_in[gi]),
                .data_we_i(data_we),
                .dir_we_i(dir_we),
                .wdat_i(wbyte),
                .impl_mask_i(impl_mask[gi]),
                .dir_mask_i(dir_mask[gi]),
                .pin_o(pin_out[gi]),
                .pin_oe_o(pin_oe[gi]),
                .data_rd_o(port_data_rd[gi]),
                .dir_rd_o(port_dir_rd[gi])
            );
        end
    endgenerate

    // Read mux; unused slots and unmapped addresses give zero
    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = BYTE_ZERO;
        if (is_port_data) begin
            rd_nxt = port_data_rd[port_sel];
        end else if (is_port_dir) begin
            rd_nxt = port_dir_rd[port_sel];
        end else if (is_per && per_readable) begin
            rd_nxt = per_rdat_i;
        end else if (hit_rom) begin
            rd_nxt = rom_dat_i;
        end else if (hit_opt) begin
            rd_nxt = opt_r;
        end else if (hit_mor1) begin
            rd_nxt = mor_i[7:0];
        end else if (hit_mor2) begin
            rd_nxt = mor_i[15:8];
        end
    end

    // One wait state: data sampled on the first edge, ack the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else if (ce_i) begin
            ack_r <= take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= '0;
            per_idx_r <= '0;
            per_wdat_r <= BYTE_ZERO;
        end else if (ce_i && take) begin
            dat_r <= {24'h000000, rd_nxt};
            per_idx_r <= ofs;
            per_wdat_r <= wbyte;
        end
    end

    assign dat_o = dat_r;
    assign ack_o = ack_r;

    // Strobes fire on the ack edge, so a read side effect follows the sample
    assign per_wr_o = wr_ok & is_per & per_writable;
    assign per_rd_o = rd_ok & is_per & per_readable;
    assign per_idx_o = per_idx_r;
    assign per_wdat_o = per_wdat_r;

    // ROM is read-only: no write path exists for it
    assign rom_adr_o = cpu_adr[7:0];

    // Not reset: the straps must reach the capture flops while reset is held
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            strap_meta_r <= {sec_nv_i, otp_part_i, large_cfg_i, boot_mode_i};
            strap_sync_r <= strap_meta_r;
        end
    end

    // Size and OTP straps follow the pins during reset and freeze after its release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            large_r <= large_s;
            otp_r <= otp_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_r <= OPT_RESET;
        end else if (ce_i && wr_ok && hit_opt) begin
            opt_r <= wbyte;
        end
    end
    assign option_o = opt_r;

    // Security lock; a set in the same cycle as an erase wins
    wire logic sec_set = wr_ok & hit_mor2 & wbyte[MOR2_SEC_BIT];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Lock state lives in the nonvolatile array; reload it here
            lock_r <= sec_nv_s;
        end else if (ce_i) begin
            if (sec_set) begin
                lock_r <= 1'b1;
            end else if (erase_done_i && !otp_r) begin
                lock_r <= 1'b0;
            end
        end
    end
    assign sec_burn_o = sec_set;
    assign sec_lock_o = lock_r;

    // External reads are refused in every mode while locked
    assign ext_rd_grant_o = ext_rd_req_i & ~lock_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_dat_r <= BYTE_ZERO;
        end else if (ce_i) begin
            ext_dat_r <= ext_rd_grant_o ? ext_mem_dat_i : BYTE_ZERO;
        end
    end
    assign ext_rd_dat_o = ext_dat_r;

    assign rom_exec_o = boot_s;

    // Small configuration clears the watchdog through the high-memory slot
    assign wdog_alt_clr_o = wr_ok & hit_walt & ~large_r;
endmodule

/* test/pzr_cpu_side_model.sv */
`timescale 1ns/1ns
module pzr_cpu_side_model (
    input wire logic [15:0] bus_adr_i,
    input wire logic [7:0] rom_adr_i,
    output logic [7:0] per_rdat_o,
    output logic [7:0] rom_dat_o,
    output logic [7:0] mem_dat_o
);
    // Slots answer with their own index, so a wrong decode shows
    assign per_rdat_o = {3'b110, bus_adr_i[6:2]};
    // Inverted address as image, so stuck address lines show
    assign rom_dat_o = ~rom_adr_i;
    assign mem_dat_o = 8'h3c;
endmodule

/* test/pzr_regmap_checker.sv */
`timescale 1ns/1ns
module pzr_regmap_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic per_wr_o,
    input wire logic per_rd_o,
    input wire logic [4:0] per_idx_o,
    input wire logic erase_done_i,
    input wire logic ext_rd_req_i,
    input wire logic ext_rd_grant_o,
    input wire logic [7:0] ext_rd_dat_o,
    input wire logic sec_lock_o,
    input wire logic [7:0] port_a_pin_o,
    input wire logic [7:0] port_a_pin_oe_o,
    input wire logic [7:0] port_d_pin_o,
    input wire logic [7:0] port_d_pin_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
    property p_ack_answer; cyc_i && stb_i && ce_i && !ack_o |=> ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
    property p_ack_cause; $rose(ack_o) |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_upper_zero; ack_o |-> dat_o[31:8] == 24'h000000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_per_slot; per_wr_o || per_rd_o |-> ack_o && per_idx_o inside {[5'h0a:5'h1e]};
    endproperty
    a_per_slot: assert property (p_per_slot) else $error("strobe outside slots");
    property p_grant; ext_rd_grant_o == (ext_rd_req_i && !sec_lock_o); endproperty
    a_grant: assert property (p_grant) else $error("read granted while locked");
    property p_ext_zero; !ext_rd_grant_o |=> ext_rd_dat_o == 8'h00; endproperty
    a_ext_zero: assert property (p_ext_zero) else $error("locked data leaked");
    property p_lock_hold; $fell(sec_lock_o) && !$past(rst_i) |-> $past(erase_done_i); endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock cleared w/o erase");
    property p_dir_reset; $past(rst_i) |-> port_a_pin_oe_o == 8'h00; endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");
    property p_pd6; port_d_pin_oe_o[6] == 1'b0 && port_d_pin_o[6] == 1'b0; endproperty
    a_pd6: assert property (p_pd6) else $error("port d bit six active");
endmodule

bind pzr_regmap pzr_regmap_checker u_chk (
    .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .dat_o, .ack_o, .per_wr_o, .per_rd_o, .per_idx_o,
    .erase_done_i, .ext_rd_req_i, .ext_rd_grant_o, .ext_rd_dat_o, .sec_lock_o,
    .port_a_pin_o, .port_a_pin_oe_o, .port_d_pin_o, .port_d_pin_oe_o
);

/* test/test_pzr_regmap.sv */
`timescale 1ns/1ns
module test_pzr_regmap;
    import pzr_pkg::*;
    typedef struct packed {logic [15:0] a; logic w; logic [7:0] d; logic [7:0] e; logic p;} pzr_row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic boot_mode_i = 1'b1, otp_part_i = 1'b1, sec_nv_i = 1'b0, large_cfg_i = 1'b1;
    logic erase_done_i = 1'b0, ext_rd_req_i = 1'b0;
    logic [15:0] adr_i = 16'h0000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [7:0] pin_c = 8'h69;
    logic [31:0] dat_o;
    logic ack_o, per_wr_o, per_rd_o, rom_exec_o, sec_burn_o, ext_rd_grant_o, sec_lock_o;
    logic wdog_alt_clr_o;
    logic [4:0] per_idx_o;
    logic [7:0] per_wdat_o, per_rdat_i, rom_adr_o, rom_dat_i, ext_mem_dat_i, ext_rd_dat_o;
    logic [7:0] option_o, port_a_pin_o, port_a_pin_oe_o, port_d_pin_o, port_d_pin_oe_o;
    int n_errors = 0;
    int num_checks = 0;
    pzr_row_t rows [0:26] = '{
        '{16'h0010, 1'b1, 8'hff, 8'h00, 1'b0}, '{16'h0000, 1'b1, 8'h3c, 8'h00, 1'b0},
        '{16'h0000, 1'b0, 8'h00, 8'h3c, 1'b0}, '{16'h0014, 1'b1, 8'h0f, 8'h00, 1'b0},
        '{16'h0004, 1'b1, 8'ha5, 8'h00, 1'b0}, '{16'h0004, 1'b0, 8'h00, 8'he5, 1'b0},
        '{16'h0008, 1'b0, 8'h00, 8'h69, 1'b0}, '{16'h001c, 1'b1, 8'hff, 8'h00, 1'b0},
        '{16'h001c, 1'b0, 8'h00, 8'hbf, 1'b0}, '{16'h000c, 1'b1, 8'hff, 8'h00, 1'b0},
        '{16'h000c, 1'b0, 8'h00, 8'hbf, 1'b0}, '{16'h0020, 1'b1, 8'hff, 8'h00, 1'b0},
        '{16'h0020, 1'b0, 8'h00, 8'h00, 1'b0}, '{16'h0024, 1'b0, 8'h00, 8'h00, 1'b0},
        '{16'h007c, 1'b1, 8'hff, 8'h00, 1'b0}, '{16'h007c, 1'b0, 8'h00, 8'h00, 1'b0},
        '{16'h0028, 1'b1, 8'h77, 8'h00, 1'b1}, '{16'h0028, 1'b0, 8'h00, 8'hca, 1'b1},
        '{16'h0040, 1'b1, 8'h00, 8'h00, 1'b0}, '{16'h0078, 1'b0, 8'h00, 8'hde, 1'b1},
        '{16'hfc00, 1'b0, 8'h00, 8'hff, 1'b0}, '{16'hffb8, 1'b0, 8'h00, 8'h11, 1'b0},
        '{16'hffbc, 1'b1, 8'h5a, 8'h00, 1'b0}, '{16'hffbc, 1'b0, 8'h00, 8'h5a, 1'b0},
        '{16'hffc0, 1'b0, 8'h00, 8'h34, 1'b0}, '{16'hffc4, 1'b0, 8'h00, 8'h12, 1'b0},
        '{16'hffc0, 1'b1, 8'h00, 8'h00, 1'b0}};

    pzr_regmap dut (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .port_a_pin_i(8'h11), .port_b_pin_i(8'he7),
        .port_c_pin_i(pin_c), .port_d_pin_i(8'hff), .port_a_pin_o, .port_b_pin_o(),
        .port_c_pin_o(), .port_d_pin_o, .port_a_pin_oe_o, .port_b_pin_oe_o(),
        .port_c_pin_oe_o(), .port_d_pin_oe_o, .per_wr_o, .per_rd_o, .per_idx_o, .per_wdat_o,
        .per_rdat_i, .rom_adr_o, .rom_dat_i, .rom_exec_o, .boot_mode_i, .large_cfg_i,
        .otp_part_i, .sec_nv_i, .mor_i(16'h1234), .sec_burn_o, .erase_done_i, .ext_rd_req_i,
        .ext_mem_dat_i, .ext_rd_grant_o, .ext_rd_dat_o, .wdog_alt_clr_o, .option_o,
        .sec_lock_o);
    pzr_cpu_side_model u_far (.bus_adr_i(adr_i), .rom_adr_i(rom_adr_o), .per_rdat_o(per_rdat_i),
        .rom_dat_o(rom_dat_i), .mem_dat_o(ext_mem_dat_i));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic summarize;
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        num_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Strobes are sampled at the ack edge, before that edge's updates land
    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] r, output logic p);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        sel_i <= 4'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) begin
            n_errors++;
            summarize();
        end
        r = dat_o[7:0];
        p = per_wr_o | per_rd_o | sec_burn_o | wdog_alt_clr_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Four edges so the straps cross the synchroniser inside reset
    task automatic reset_for(input int n);
        rst_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic erase_pulse;
        erase_done_i <= 1'b1;
        @(posedge clk_i);
        erase_done_i <= 1'b0;
        @(posedge clk_i);
    endtask

    initial begin
        logic [7:0] r;
        logic p;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            bus(rows[i].a, rows[i].w, rows[i].d, r, p);
            chk($sformatf("strobe %h", rows[i].a), {7'h00, rows[i].p}, {7'h00, p});
            if (!rows[i].w) chk($sformatf("read %h", rows[i].a), rows[i].e, r);
            if (rows[i].w && rows[i].p) chk("per wdat", rows[i].d, per_wdat_o);
        end
        chk("option", 8'h5a, option_o);
        chk("boot exec", 8'h01, {7'h00, rom_exec_o});
        chk("pin a out", 8'h3c, port_a_pin_o);
        pin_c <= 8'h96;
        repeat (3) @(posedge clk_i);
        bus(16'h0008, 1'b0, 8'h00, r, p);
        chk("pin c in", 8'h96, r);
        reset_for(4);
        chk("oe a", 8'h00, port_a_pin_oe_o);
        bus(16'h0010, 1'b0, 8'h00, r, p);
        chk("dir a", 8'h00, r);
        bus(16'h0010, 1'b1, 8'hff, r, p);
        bus(16'h0000, 1'b0, 8'h00, r, p);
        chk("data a kept", 8'h3c, r);
        ext_rd_req_i <= 1'b1;
        bus(16'hffc4, 1'b1, 8'h08, r, p);
        chk("burn", 8'h01, {7'h00, p});
        // Array has burned the lock
        sec_nv_i <= 1'b1;
        @(posedge clk_i);
        chk("lock set", 8'h01, {7'h00, sec_lock_o});
        chk("grant", 8'h00, {7'h00, ext_rd_grant_o});
        chk("ext data", 8'h00, ext_rd_dat_o);
        erase_pulse();
        chk("lock otp", 8'h01, {7'h00, sec_lock_o});
        otp_part_i <= 1'b0;
        reset_for(4);
        chk("lock reset", 8'h01, {7'h00, sec_lock_o});
        sec_nv_i <= 1'b0;
        erase_pulse();
        chk("lock erased", 8'h00, {7'h00, sec_lock_o});
        chk("grant open", 8'h01, {7'h00, ext_rd_grant_o});
        @(posedge clk_i);
        chk("ext data open", 8'h3c, ext_rd_dat_o);
        large_cfg_i <= 1'b0;
        reset_for(4);
        bus(16'h001c, 1'b1, 8'hff, r, p);
        bus(16'h001c, 1'b0, 8'h00, r, p);
        chk("dir d small", 8'h00, r);
        bus(16'hffc0, 1'b1, 8'h00, r, p);
        chk("alt clear", 8'h01, {7'h00, p});
        summarize();
    end
endmodule
